// ### pkg/stl_pkg.sv
// Package with register map, field positions and shared types of the split timer.
package stl_pkg;

   // -----------------------------------------------------------------
   // Register map (byte addresses, one word each)
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CLKSEL = 8'h04;
   localparam logic [7:0] ADDR_RELOAD = 8'h08;
   localparam logic [7:0] ADDR_COUNT = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_MASK = 8'h14;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int CTRL_RUN = 0;
   localparam int CTRL_SPLIT = 1;
   localparam int CTRL_XCLK = 2;
   localparam int CTRL_LOWIRQ = 3;
   localparam int CTRL_CAPEN = 4;
   localparam int CTRL_TIE = 5;
   localparam int CLK_FASTL = 0;
   localparam int CLK_FASTH = 1;
   localparam int ST_HIGH = 0;
   localparam int ST_LOW = 1;
   localparam int ST_CAP = 2;
   localparam int ST_W = 3;

   // -----------------------------------------------------------------
   // Timing and reset values
   // -----------------------------------------------------------------
   localparam int SYS_DIV = 12;
   localparam int EXT_DIV = 8;
   localparam logic [7:0] BYTE_MAX = 8'hff;
   localparam logic [15:0] WORD_MAX = 16'hffff;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [ST_W-1:0] ST_ZERO = 3'h0;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic tie;
      logic capen;
      logic lowirq;
      logic xclk;
      logic split;
      logic run;
   } stl_ctrl_t;

   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } stl_word_t;

   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_ACK
   } stl_bus_t;

endpackage

// ### rtl/stl_edge_sync.sv
// Three-stage pin synchroniser with agreeing-stage edge detection.
`timescale 1ns/1ns
module stl_edge_sync (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Pin side
   input wire logic pin_i,
   // Synchronised side
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);

   logic s1_q;
   logic s2_q;
   logic s3_q;

   // The first stage is read only by the second stage.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A change counts once the second and third stages agree.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_o <= 1'b0;
         rise_o <= 1'b0;
         fall_o <= 1'b0;
      end else begin
         rise_o <= s2_q & s3_q & ~level_o;
         fall_o <= ~s2_q & ~s3_q & level_o;
         if (s2_q == s3_q) begin
            level_o <= s3_q;
         end
      end
   end

endmodule

// ### rtl/stl_timer.sv
// Split or 16-bit timer with LOW_FREQUENCY_OSCILLATOR falling-edge capture and Wishbone registers.
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
// Operation
// - Split mode runs two 8-bit auto-reload counters.
// - Each half reloads from its own reload byte.
// - Run bit gates high half only in split.
// - High clock: fast, system_clock/12 or ext/8.
// - Low clock: fast, system_clock/12 or ext/8.
// - High wrap sets high overflow flag.
// - Low wrap sets low overflow flag.
// - Timer interrupt on high overflow by default.
// - Low irq enable adds low overflow interrupt.
// - Flags stay set until software clears.
// - Capture enable selects LOW_FREQUENCY_OSCILLATOR falling-edge capture.
// - Non-split counts up 16 bits, wraps.
// - Capture copies count into reload registers in 16-bit mode only.
// - Capture event raises interrupt when enabled.
module stl_timer (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Pins
   input wire logic ext_clk_i,
   input wire logic lfo_i,
   // Interrupt
   output logic irq_o
);
   import stl_pkg::*;

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   stl_ctrl_t ctrl_q;
   logic fast_lo_q;
   logic fast_hi_q;
   stl_word_t reload_q;
   stl_word_t count_q;
   logic [ST_W-1:0] status_q;
   logic [ST_W-1:0] mask_q;
   stl_bus_t bus_q;
   logic [3:0] sys_div_q;
   logic sys_tick_q;
   logic [2:0] ext_div_q;
   logic ext_tick_q;

   logic ext_rise;
   logic lfo_fall;
   logic wr_en;
   logic rd_sel;
   logic slow_tick;
   logic tick_lo;
   logic tick_hi;
   logic ovf_lo;
   logic ovf_hi;
   logic cap_ev;
   logic [ST_W-1:0] ev_set;
   logic [ST_W-1:0] irq_src;

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   stl_edge_sync u_ext_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(ext_clk_i),
      .level_o(),
      .rise_o(ext_rise),
      .fall_o()
   );

   stl_edge_sync u_lfo_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(lfo_i),
      .level_o(),
      .rise_o(),
      .fall_o(lfo_fall)
   );

   // -----------------------------------------------------------------
   // Prescalers
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sys_div_q <= 4'h0;
         sys_tick_q <= 1'b0;
      end else if (sys_div_q == 4'(SYS_DIV - 1)) begin
         sys_div_q <= 4'h0;
         sys_tick_q <= 1'b1;
      end else begin
         sys_div_q <= sys_div_q + 4'h1;
         sys_tick_q <= 1'b0;
      end
   end

   // The external clock is sampled, so it must stay well below clk_i / 4.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_div_q <= 3'h0;
         ext_tick_q <= 1'b0;
      end else begin
         ext_tick_q <= ext_rise && (ext_div_q == 3'(EXT_DIV - 1));
         if (ext_rise) begin
            ext_div_q <= ext_div_q + 3'h1;
         end
      end
   end

   assign slow_tick = ctrl_q.xclk ? ext_tick_q : sys_tick_q;
   assign tick_hi = (fast_hi_q | slow_tick) & (ctrl_q.run | ~ctrl_q.split);
   assign tick_lo = fast_lo_q | slow_tick;

   // -----------------------------------------------------------------
   // Counter
   // -----------------------------------------------------------------
   assign ovf_lo = ctrl_q.split & tick_lo & (count_q.lo == BYTE_MAX);
   assign ovf_hi = ctrl_q.split ? (tick_hi & (count_q.hi == BYTE_MAX))
                                : (tick_hi & (count_q == WORD_MAX));
   assign cap_ev = ctrl_q.capen & lfo_fall;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_q <= '0;
      end else if (wr_en && wb_adr_i == ADDR_COUNT) begin
         if (wb_sel_i[0]) begin
            count_q.lo <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            count_q.hi <= wb_dat_i[15:8];
         end
      end else if (ctrl_q.split) begin
         if (ovf_lo) begin
            count_q.lo <= reload_q.lo;
         end else if (tick_lo) begin
            count_q.lo <= count_q.lo + 8'h01;
         end
         if (ovf_hi) begin
            count_q.hi <= reload_q.hi;
         end else if (tick_hi) begin
            count_q.hi <= count_q.hi + 8'h01;
         end
      end else if (tick_hi) begin
         count_q <= count_q + 16'h0001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reload_q <= '0;
      end else if (cap_ev && !ctrl_q.split) begin
         reload_q <= count_q;
      end else if (wr_en && wb_adr_i == ADDR_RELOAD) begin
         if (wb_sel_i[0]) begin
            reload_q.lo <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            reload_q.hi <= wb_dat_i[15:8];
         end
      end
   end

   // -----------------------------------------------------------------
   // Flags and interrupt
   // -----------------------------------------------------------------
   always_comb begin
      ev_set = ST_ZERO;
      ev_set[ST_HIGH] = ovf_hi;
      ev_set[ST_LOW] = ovf_lo;
      ev_set[ST_CAP] = cap_ev & ~ctrl_q.split;
   end

   // Set wins over a write-one clear in the same cycle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_q <= ST_ZERO;
      end else if (wr_en && wb_adr_i == ADDR_STATUS && wb_sel_i[0]) begin
         status_q <= (status_q & ~wb_dat_i[ST_W-1:0]) | ev_set;
      end else begin
         status_q <= status_q | ev_set;
      end
   end

   always_comb begin
      irq_src = status_q & mask_q;
      irq_src[ST_LOW] = irq_src[ST_LOW] & ctrl_q.lowirq;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= ctrl_q.tie & (|irq_src);
      end
   end

   // -----------------------------------------------------------------
   // Wishbone slave
   // -----------------------------------------------------------------
   assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & (bus_q == BUS_IDLE);
   assign rd_sel = wb_cyc_i & wb_stb_i & ~wb_we_i & (bus_q == BUS_IDLE);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_q <= BUS_IDLE;
         wb_ack_o <= 1'b0;
      end else begin
         unique case (bus_q)
            BUS_IDLE: begin
               if (wb_cyc_i && wb_stb_i) begin
                  bus_q <= BUS_ACK;
                  wb_ack_o <= 1'b1;
               end
            end
            BUS_ACK: begin
               bus_q <= BUS_IDLE;
               wb_ack_o <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= '0;
         fast_lo_q <= 1'b0;
         fast_hi_q <= 1'b0;
         mask_q <= ST_ZERO;
      end else if (wr_en && wb_sel_i[0]) begin
         if (wb_adr_i == ADDR_CTRL) begin
            ctrl_q <= stl_ctrl_t'(wb_dat_i[CTRL_TIE:0]);
         end
         if (wb_adr_i == ADDR_CLKSEL) begin
            fast_lo_q <= wb_dat_i[CLK_FASTL];
            fast_hi_q <= wb_dat_i[CLK_FASTH];
         end
         if (wb_adr_i == ADDR_MASK) begin
            mask_q <= wb_dat_i[ST_W-1:0];
         end
      end
   end

   // Unmapped addresses answer with zero data and a normal ack.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= '0;
      end else if (rd_sel) begin
         wb_dat_o <= '0;
         unique case (wb_adr_i)
            ADDR_CTRL: wb_dat_o[CTRL_TIE:0] <= ctrl_q;
            ADDR_CLKSEL: wb_dat_o[CLK_FASTH:0] <= {fast_hi_q, fast_lo_q};
            ADDR_RELOAD: wb_dat_o[15:0] <= reload_q;
            ADDR_COUNT: wb_dat_o[15:0] <= count_q;
            ADDR_STATUS: wb_dat_o[ST_W-1:0] <= status_q;
            ADDR_MASK: wb_dat_o[ST_W-1:0] <= mask_q;
            default: wb_dat_o <= '0;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   sequence s_lo_wrap;
      ctrl_q.split && tick_lo && count_q.lo == BYTE_MAX && !wr_en;
   endsequence

   low_reload_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_lo_wrap |=> count_q.lo == $past(reload_q.lo))
      else $error("low half did not reload on wrap");

   low_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_lo_wrap |=> status_q[ST_LOW])
      else $error("low overflow flag not set");

   high_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ovf_hi |=> status_q[ST_HIGH])
      else $error("high overflow flag not set");

   flag_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
      status_q[ST_HIGH] && !(wr_en && wb_adr_i == ADDR_STATUS) |=> status_q[ST_HIGH])
      else $error("flag cleared without software");

   high_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_q.split && !ctrl_q.run && !wr_en |=> count_q.hi == $past(count_q.hi))
      else $error("high half ran while stopped");

   wide_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !ctrl_q.split && tick_hi && !wr_en |=> count_q == $past(count_q) + 16'h0001)
      else $error("16-bit count did not step");

   capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cap_ev && !ctrl_q.split |=> reload_q == $past(count_q))
      else $error("capture did not latch count");

   low_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !ctrl_q.lowirq && status_q == 3'h2 |=> !irq_o)
      else $error("low overflow raised irq while disabled");

   cap_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_q.tie && mask_q[ST_CAP] && status_q[ST_CAP] |=> irq_o)
      else $error("capture irq missing");

   sys_div_a: assert property (@(posedge clk_i) disable iff (rst_i)
      sys_tick_q |=> !sys_tick_q [*8] ##1 !sys_tick_q [*3] ##1 sys_tick_q)
      else $error("system_clock divider period wrong");

   // Writes are left out so that a software load never looks like a missed reload.
   sequence s_hi_wrap;
      ctrl_q.split && tick_hi && count_q.hi == BYTE_MAX && !wr_en;
   endsequence

   high_reload_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_hi_wrap |=> count_q.hi == $past(reload_q.hi))
      else $error("high half did not reload on wrap");

   wrap_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !ctrl_q.split && tick_hi && count_q == WORD_MAX && !wr_en
      |=> count_q.hi == BYTE_ZERO && count_q.lo == BYTE_ZERO)
      else $error("16-bit count did not wrap to zero");

   low_runs_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_q.split && !ctrl_q.run && tick_lo && !wr_en && count_q.lo != BYTE_MAX
      |=> count_q.lo == $past(count_q.lo) + 8'h01)
      else $error("low half stopped with the run bit");

   low_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
      status_q[ST_LOW] && !(wr_en && wb_adr_i == ADDR_STATUS) |=> status_q[ST_LOW])
      else $error("low flag cleared without software");

   low_irq_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_q.tie && ctrl_q.lowirq && mask_q[ST_LOW] && status_q[ST_LOW] |=> irq_o)
      else $error("low overflow irq missing");

   cap_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cap_ev && !ctrl_q.split |=> status_q[ST_CAP])
      else $error("capture flag not set");

endmodule

// ### verif/stl_timer_tb.sv
// Self-checking testbench for the split timer.
`timescale 1ns/1ns
module stl_timer_tb;
   import stl_pkg::*;
   // -----------------------------------------------------------------
   // Signals
   // -----------------------------------------------------------------
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic ext_clk_i = 1'b0;
   logic lfo_i = 1'b1;
   logic irq_o;
   int num_errors = 0;
   int checks = 0;
   logic [31:0] rd;
   logic [31:0] cnt;
   typedef struct {logic [7:0] adr; logic [31:0] dat; logic [31:0] exp;} stl_row_t;
   stl_row_t rows [5] = '{'{ADDR_MASK, 32'h7, 32'h7}, '{ADDR_CLKSEL, 32'h3, 32'h3},
      '{ADDR_RELOAD, 32'h1234, 32'h1234}, '{ADDR_CTRL, 32'h2a, 32'h2a},
      '{8'h18, 32'h55, 32'h0}};

   stl_timer u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clk_i(ext_clk_i), .lfo_i(lfo_i),
      .irq_o(irq_o));

   initial begin
      forever #50 clk_i = ~clk_i;
   end

   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic stop_test();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One classic cycle; the request is held until ack is sampled high.
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hf;
      wb_dat_i <= dat;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1);
      check("ack delay", n, 32'h2);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic in_range(input string name, input logic [7:0] v, input int lo, input int hi);
      check(name, {31'h0, (v >= lo && v <= hi)}, 32'h1);
   endtask

   // -----------------------------------------------------------------
   // Watchdog
   // -----------------------------------------------------------------
   initial begin
      #(100 * 20000);
      num_errors++;
      stop_test();
   end

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      idle(8);
      rst_i <= 1'b0;
      foreach (rows[i]) begin
         wb(1'b1, rows[i].adr, rows[i].dat);
         wb(1'b0, rows[i].adr, 32'h0);
         check("readback", rd, rows[i].exp);
      end
      // A second reset must bring control, mask, status and irq back to zero.
      @(posedge clk_i);
      rst_i <= 1'b1;
      idle(3);
      rst_i <= 1'b0;
      wb(1'b0, ADDR_CTRL, 32'h0);
      check("ctrl rst", rd, 32'h0);
      wb(1'b0, ADDR_MASK, 32'h0);
      check("mask rst", rd, 32'h0);
      wb(1'b0, ADDR_STATUS, 32'h0);
      check("status rst", rd, 32'h0);
      check("irq rst", {31'h0, irq_o}, 32'h0);
      // Split mode, low half fast, high half stopped.
      wb(1'b1, ADDR_CTRL, 32'h02);
      wb(1'b1, ADDR_RELOAD, 32'h2010);
      wb(1'b1, ADDR_COUNT, 32'hfff0);
      wb(1'b1, ADDR_CLKSEL, 32'h3);
      idle(40);
      wb(1'b0, ADDR_STATUS, 32'h0);
      check("low flag", rd, 32'h2);
      wb(1'b0, ADDR_COUNT, 32'h0);
      check("hi held", {24'h0, rd[15:8]}, 32'hff);
      in_range("lo reload", rd[7:0], 8'h10, 8'h50);
      wb(1'b1, ADDR_MASK, 32'h7);
      wb(1'b1, ADDR_CTRL, 32'h22);
      idle(3);
      check("irq high only", {31'h0, irq_o}, 32'h0);
      wb(1'b1, ADDR_CTRL, 32'h2a);
      idle(3);
      check("irq low", {31'h0, irq_o}, 32'h1);
      wb(1'b0, ADDR_STATUS, 32'h0);
      check("sticky", rd, 32'h2);
      // Starting the high half makes it wrap at once.
      wb(1'b1, ADDR_CTRL, 32'h23);
      idle(10);
      wb(1'b0, ADDR_STATUS, 32'h0);
      check("high flag", rd[0], 1'b1);
      wb(1'b0, ADDR_COUNT, 32'h0);
      in_range("hi reload", rd[15:8], 8'h20, 8'h40);
      check("irq high", {31'h0, irq_o}, 32'h1);
      // Slow 16-bit mode cannot overflow while the flags are cleared.
      wb(1'b1, ADDR_CTRL, 32'h20);
      wb(1'b1, ADDR_CLKSEL, 32'h0);
      wb(1'b1, ADDR_COUNT, 32'h0);
      wb(1'b1, ADDR_STATUS, 32'h7);
      wb(1'b0, ADDR_STATUS, 32'h0);
      check("cleared", rd, 32'h0);
      idle(2);
      check("irq off", {31'h0, irq_o}, 32'h0);
      // A 16-bit wrap goes to zero, not to the reload value.
      wb(1'b1, ADDR_CLKSEL, 32'h3);
      wb(1'b1, ADDR_COUNT, 32'hfff0);
      idle(30);
      wb(1'b0, ADDR_STATUS, 32'h0);
      check("wrap16 flag", rd, 32'h1);
      wb(1'b0, ADDR_COUNT, 32'h0);
      check("wrap16 hi", {24'h0, rd[15:8]}, 32'h0);
      // Divide by twelve on both halves.
      wb(1'b1, ADDR_CLKSEL, 32'h0);
      wb(1'b1, ADDR_CTRL, 32'h03);
      wb(1'b1, ADDR_COUNT, 32'h0);
      idle(237);
      wb(1'b0, ADDR_COUNT, 32'h0);
      in_range("lo div12", rd[7:0], 19, 21);
      in_range("hi div12", rd[15:8], 19, 21);
      // Divide by eight of the external pin; 32 rising edges give 4 ticks.
      wb(1'b1, ADDR_CTRL, 32'h07);
      wb(1'b1, ADDR_COUNT, 32'h0);
      repeat (64) begin
         @(posedge clk_i);
         ext_clk_i <= ~ext_clk_i;
         idle(4);
      end
      idle(10);
      wb(1'b0, ADDR_COUNT, 32'h0);
      check("ext div8", rd, 32'h0404);
      // Capture on a falling edge of the low-frequency pin.
      wb(1'b1, ADDR_CTRL, 32'h30);
      wb(1'b1, ADDR_CLKSEL, 32'h3);
      wb(1'b1, ADDR_STATUS, 32'h7);
      @(posedge clk_i);
      lfo_i <= 1'b0;
      idle(20);
      wb(1'b0, ADDR_STATUS, 32'h0);
      check("cap flag", rd, 32'h4);
      check("cap irq", {31'h0, irq_o}, 32'h1);
      wb(1'b0, ADDR_COUNT, 32'h0);
      cnt = rd;
      wb(1'b0, ADDR_RELOAD, 32'h0);
      check("cap value", {31'h0, (rd < cnt && rd + 32'h40 > cnt)}, 32'h1);
      stop_test();
   end
endmodule
